// >>> hdl/rsb_backend.sv
// Status word, command word and transfer status bookkeeping toward the backend memory
// Overview of operation
// RULE1 - Outside logic latches command value on strobes
// RULE2 - Seven-bit vector: subaddress and transmit flag
// RULE3 - Status bits 15:11 carry terminal address
// RULE4 - Status bit 10 set on message error
// RULE5 - Status bits 9, 7:5, 1 always zero
// RULE6 - Status bits 8 and 2 follow subsystem flag
// RULE7 - Bit 4 broadcast received, bit 3 busy
// RULE8 - Bit 0 terminal flag unless inhibited
// RULE9 - Command word written at transfer start
// RULE10 - Command write suppressed when enable low
// RULE11 - Status record written to same location
// RULE12 - Status record writes can be disabled
// RULE13 - Backend completes each access within 1.0 us
// RULE14 - Command write then first data fetch
// RULE15 - Last data word before status record
// RULE16 - Abort access at 1.0 us, flag bit 8
// RULE17 - Record bit 15 set at completion
// RULE18 - Bit 14 set when bits 11:5 clear
// RULE19 - Bit 13 receiving bus, bit 12 broadcast
// RULE20 - Bits 11,10 loopback fails, bit 9 illegal
// RULE21 - Bits 7,6,5 biphase, odd check, count errors
// RULE22 - Count field, zero meaning, mode code subaddresses
// RULE23 - Status record overwrites command word location
`timescale 1ns/1ps
module rsb_backend (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Pins from outside the clock domain
  input wire logic [4:0] terminal_address_input,
  input wire logic subsystem_flag_input,
  input wire logic terminal_busy_input,
  input wire logic terminal_flag_input,
  input wire logic command_write_enable,
  input wire logic status_record_write_enable,
  // Protocol logic events, same clock
  input wire logic cmd_start,
  input wire logic [15:0] cmd_word,
  input wire logic msg_error_set,
  input wire logic bcast_rx_set,
  input wire logic inhibit_terminal_flag_input_set,
  input wire logic inhibit_terminal_flag_input_clr,
  input wire logic xfer_end,
  input wire logic bus_select_flag,
  input wire logic xfer_broadcast,
  input wire rsb_pkg::rsb_xfer_err_t xfer_err,
  input wire logic [4:0] word_count,
  // Protocol data accesses
  input wire logic data_req,
  input wire rsb_pkg::rsb_data_req_t data_req_info,
  output logic data_ready,
  output logic data_done,
  output logic data_fail,
  output logic [15:0] data_rdata,
  // Backend memory port
  output logic mem_req_n,
  input wire logic mem_gnt_n,
  output logic mem_write,
  output rsb_pkg::rsb_oper_t mem_oper,
  output logic [10:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  // Status and mapping outputs
  output logic [15:0] status_word,
  output logic [15:0] transfer_status_record,
  output logic [15:0] command_value_bus,
  output logic address_latch_strobe,
  output logic interrupt_latch_strobe,
  output logic [6:0] int_vector,
  output logic memory_timeout_flag
);

  rsb_pkg::rsb_state_t r_r;
  rsb_pkg::rsb_state_t r_nxt;
  rsb_pkg::rsb_pins_t pins_in;
  logic timeout;
  logic run_timer;
  logic gnt_low;
  logic [4:0] cur_sa;
  logic [10:0] rec_addr;
  logic [15:0] tsw_build;
  logic [6:0] err_bits;
  logic fail_now;

  // Gather the asynchronous pins into one synchroniser word
  always_comb begin
    pins_in.terminal_address_input = terminal_address_input;
    pins_in.subsystem_flag_input = subsystem_flag_input;
    pins_in.terminal_busy_input = terminal_busy_input;
    pins_in.terminal_flag_input = terminal_flag_input;
    pins_in.command_write_enable = command_write_enable;
    pins_in.status_record_write_enable = status_record_write_enable;
    pins_in.mem_gnt_n = mem_gnt_n;
  end

  // Open access runs the watchdog
  // Request and release phases both count toward the limit
  assign run_timer = (r_r.fsm != rsb_pkg::RSB_IDLE);

  // RULE16 - access time watchdog
  rsb_access_timer u_timer (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .run(run_timer),
    .timeout(timeout)
  );

  // Grant seen only after the filter agrees
  // Costs a few cycles per edge but never sees a metastable grant
  assign gnt_low = ~r_r.pf.mem_gnt_n;

  // Subaddress of the current command
  assign cur_sa = r_r.cmd[rsb_pkg::CMD_SA_HI:rsb_pkg::CMD_SA_LO];

  // RULE9 - receive and transmit record bases
  // RULE11 - same location for the status record
  assign rec_addr = r_r.cmd[rsb_pkg::CMD_TX_BIT] ? {rsb_pkg::TX_REC_BASE, cur_sa}
                                                 : {rsb_pkg::RX_REC_BASE, cur_sa};

  // A timeout this cycle still counts toward the record
  assign fail_now = r_r.mem_fail | timeout;

  // RULE20 - loopback and illegal flags
  // RULE21 - incoming data errors
  // RULE16 - memory timeout in bit 8
  assign err_bits = {xfer_err.loopback_fail_b, xfer_err.loopback_fail_a,
                     xfer_err.illegal_cmd, fail_now, xfer_err.biphase_code_error,
                     xfer_err.odd_check_error, xfer_err.word_count_error};

  // Transfer status record assembly
  always_comb begin
    tsw_build = rsb_pkg::WORD_RST;
    // RULE17 - completion mark
    tsw_build[rsb_pkg::TS_USED] = 1'b1;
    // RULE18 - clean transfer mark
    tsw_build[rsb_pkg::TS_OK] = ~|err_bits;
    // RULE19 - bus and broadcast
    tsw_build[rsb_pkg::TS_BUS] = bus_select_flag;
    tsw_build[rsb_pkg::TS_BCAST] = xfer_broadcast;
    tsw_build[rsb_pkg::TS_ERR_HI:rsb_pkg::TS_ERR_LO] = err_bits;
    // RULE22 - mode code or word count
    if (cur_sa == rsb_pkg::SA_MODE_LO || cur_sa == rsb_pkg::SA_MODE_HI) begin
      tsw_build[4:0] = r_r.cmd[4:0];
    end else begin
      tsw_build[4:0] = word_count;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    r_nxt = r_r;
    // Three-stage synchroniser, change taken when stages two and three agree
    r_nxt.s1 = pins_in;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    // A one-cycle glitch never reaches the filtered copy
    if (r_r.s2 == r_r.s3) begin
      r_nxt.pf = r_r.s3;
    end
    r_nxt.addr_strobe = 1'b0;
    r_nxt.int_strobe = 1'b0;
    r_nxt.data_done = 1'b0;
    r_nxt.data_fail = 1'b0;

    // Backend access sequencer
    case (r_r.fsm)
      rsb_pkg::RSB_IDLE: begin
        // RULE14 - command write ahead of data fetch
        if (r_r.pend_cmd) begin
          r_nxt.pend_cmd = 1'b0;
          r_nxt.mem.req_n = 1'b0;
          r_nxt.mem.write = 1'b1;
          r_nxt.mem.oper = rsb_pkg::RSB_OP_CMD;
          r_nxt.mem.addr = rec_addr;
          r_nxt.mem.wdata = r_r.cmd;
          r_nxt.fsm = rsb_pkg::RSB_REQ;
        // RULE15 - last data word before the record
        end else if (r_r.pend_data) begin
          r_nxt.pend_data = 1'b0;
          r_nxt.mem.req_n = 1'b0;
          r_nxt.mem.write = r_r.dreq.write;
          r_nxt.mem.oper = rsb_pkg::RSB_OP_DATA;
          r_nxt.mem.addr = r_r.dreq.addr;
          r_nxt.mem.wdata = r_r.dreq.wdata;
          r_nxt.fsm = rsb_pkg::RSB_REQ;
        // RULE23 - record lands on the command location
        end else if (r_r.pend_tsw) begin
          r_nxt.pend_tsw = 1'b0;
          r_nxt.mem.req_n = 1'b0;
          r_nxt.mem.write = 1'b1;
          r_nxt.mem.oper = rsb_pkg::RSB_OP_TSW;
          r_nxt.mem.addr = rec_addr;
          r_nxt.mem.wdata = r_r.tsw_word;
          r_nxt.fsm = rsb_pkg::RSB_REQ;
        end
      end
      rsb_pkg::RSB_REQ: begin
        // RULE16 - abort a late access
        if (timeout) begin
          r_nxt.mem.req_n = 1'b1;
          r_nxt.mem.oper = rsb_pkg::RSB_OP_NONE;
          r_nxt.mem_fail = 1'b1;
          r_nxt.data_done = (r_r.mem.oper == rsb_pkg::RSB_OP_DATA);
          r_nxt.data_fail = (r_r.mem.oper == rsb_pkg::RSB_OP_DATA);
          r_nxt.fsm = rsb_pkg::RSB_IDLE;
        // RULE13 - grant taken, drop the request
        end else if (gnt_low) begin
          r_nxt.mem.req_n = 1'b1;
          // Read data stands while the grant is held low
          if (!r_r.mem.write) begin
            r_nxt.rdata = mem_rdata;
          end
          r_nxt.fsm = rsb_pkg::RSB_REL;
        end
      end
      rsb_pkg::RSB_REL: begin
        // Wait for the grant to fall away so a stale grant is never reused
        if (!gnt_low || timeout) begin
          r_nxt.mem.oper = rsb_pkg::RSB_OP_NONE;
          r_nxt.data_done = (r_r.mem.oper == rsb_pkg::RSB_OP_DATA);
          r_nxt.data_fail = timeout && (r_r.mem.oper == rsb_pkg::RSB_OP_DATA);
          if (timeout) begin
            r_nxt.mem_fail = 1'b1;
          end
          r_nxt.fsm = rsb_pkg::RSB_IDLE;
        end
      end
      default: begin
        // Illegal state code: drop any open access and recover
        r_nxt.mem.req_n = 1'b1;
        r_nxt.mem.oper = rsb_pkg::RSB_OP_NONE;
        r_nxt.fsm = rsb_pkg::RSB_IDLE;
      end
    endcase

    // Data access taken only into a free slot
    // Ready is combinational, so the slot refills while an access runs
    if (data_req && !r_r.pend_data) begin
      r_nxt.pend_data = 1'b1;
      r_nxt.dreq = data_req_info;
    end

    // New command: clear per-message flags, events below win
    if (cmd_start) begin
      r_nxt.cmd = cmd_word;
      r_nxt.msg_err = 1'b0;
      r_nxt.bcast_rx = 1'b0;
      // Set beats clear: a timeout in this same cycle still marks the flag
      r_nxt.mem_fail = timeout;
      // RULE1 - value presented with its latch strobe
      r_nxt.cval = cmd_word;
      r_nxt.addr_strobe = 1'b1;
      // RULE10 - command write only when enabled
      r_nxt.pend_cmd = r_r.pf.command_write_enable;
    end

    // RULE4 - message error sticks for the message
    if (msg_error_set) begin
      r_nxt.msg_err = 1'b1;
    end
    // RULE7 - broadcast received
    if (bcast_rx_set) begin
      r_nxt.bcast_rx = 1'b1;
    end
    // RULE8 - inhibit mode, set beats override
    if (inhibit_terminal_flag_input_clr) begin
      r_nxt.inhibit = 1'b0;
    end
    if (inhibit_terminal_flag_input_set) begin
      r_nxt.inhibit = 1'b1;
    end

    // End of transfer: freeze the record and announce it
    if (xfer_end) begin
      // Frozen here, so a timeout on the record write itself is not shown
      r_nxt.tsw_word = tsw_build;
      // RULE2 - vector of clean mark, direction and subaddress
      r_nxt.int_vec = {tsw_build[rsb_pkg::TS_OK], r_r.cmd[rsb_pkg::CMD_TX_BIT], cur_sa};
      r_nxt.int_strobe = 1'b1;
      // RULE12 - record write only when enabled
      r_nxt.pend_tsw = r_r.pf.status_record_write_enable;
    end

    // Outgoing status word, rebuilt every cycle
    r_nxt.status_word = rsb_pkg::STATUS_RST;
    // RULE3 - terminal address field
    r_nxt.status_word[15:rsb_pkg::SW_ADDR_LO] = r_r.pf.terminal_address_input;
    // RULE4 - message error bit
    r_nxt.status_word[rsb_pkg::SW_MSG_ERR] = r_r.msg_err;
    // RULE6 - service request and subsystem flag
    r_nxt.status_word[rsb_pkg::SW_SERV_REQ] = r_r.pf.subsystem_flag_input;
    r_nxt.status_word[rsb_pkg::SW_SUBSYS] = r_r.pf.subsystem_flag_input;
    // RULE7 - broadcast and busy
    r_nxt.status_word[rsb_pkg::SW_BCAST] = r_r.bcast_rx;
    r_nxt.status_word[rsb_pkg::SW_BUSY] = r_r.pf.terminal_busy_input;
    // RULE8 - masked terminal flag
    r_nxt.status_word[rsb_pkg::SW_TERMINAL_FLAG_INPUT] = r_r.pf.terminal_flag_input & ~r_r.inhibit;
    // RULE5 - bits 9, 7:5 and 1 stay at the zero default
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk) begin
    if (reset) begin
      r_r <= '0;
      // Ones read as pins released and the grant withdrawn
      r_r.s1 <= '1;
      r_r.s2 <= '1;
      r_r.s3 <= '1;
      r_r.pf <= '1;
      r_r.fsm <= rsb_pkg::RSB_IDLE;
      r_r.mem.req_n <= 1'b1;
      r_r.mem.oper <= rsb_pkg::RSB_OP_NONE;
      r_r.status_word <= rsb_pkg::STATUS_RST;
      r_r.int_vec <= rsb_pkg::VEC_RST;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  // Output drive, all from flip-flops except the slot-free handshake
  assign data_ready = ~r_r.pend_data;
  assign data_done = r_r.data_done;
  assign data_fail = r_r.data_fail;
  assign data_rdata = r_r.rdata;
  assign mem_req_n = r_r.mem.req_n;
  assign mem_write = r_r.mem.write;
  assign mem_oper = r_r.mem.oper;
  assign mem_addr = r_r.mem.addr;
  assign mem_wdata = r_r.mem.wdata;
  assign status_word = r_r.status_word;
  assign transfer_status_record = r_r.tsw_word;
  assign command_value_bus = r_r.cval;
  assign address_latch_strobe = r_r.addr_strobe;
  assign interrupt_latch_strobe = r_r.int_strobe;
  assign int_vector = r_r.int_vec;
  assign memory_timeout_flag = r_r.mem_fail;

endmodule : rsb_backend

// >>> hdl/rsb_pkg.sv
// Shared constants and types for the terminal status and transfer status backend
package rsb_pkg;

  // Clock and backend access timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int ACCESS_LIMIT_NS = 1000;
  // Longest time, so round down
  localparam int TIMEOUT_CYC = ACCESS_LIMIT_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 7;

  // Memory address layout
  localparam int ADDR_W = 11;
  localparam int DATA_W = 16;
  localparam logic [5:0] RX_REC_BASE = 6'h00;
  localparam logic [5:0] TX_REC_BASE = 6'h1F;

  // Command word fields
  localparam int CMD_TX_BIT = 10;
  localparam int CMD_SA_HI = 9;
  localparam int CMD_SA_LO = 5;
  localparam logic [4:0] SA_MODE_LO = 5'h00;
  localparam logic [4:0] SA_MODE_HI = 5'h1F;

  // Status word positions
  localparam int SW_ADDR_LO = 11;
  localparam int SW_MSG_ERR = 10;
  localparam int SW_SERV_REQ = 8;
  localparam int SW_BCAST = 4;
  localparam int SW_BUSY = 3;
  localparam int SW_SUBSYS = 2;
  localparam int SW_TERMINAL_FLAG_INPUT = 0;

  // Transfer status record positions
  localparam int TS_USED = 15;
  localparam int TS_OK = 14;
  localparam int TS_BUS = 13;
  localparam int TS_BCAST = 12;
  localparam int TS_ERR_HI = 11;
  localparam int TS_ERR_LO = 5;
  localparam int TS_MEMFAIL = 8;

  // Reset values
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [6:0] VEC_RST = 7'h00;

  // Memory operation tags
  typedef enum logic [1:0] {
    RSB_OP_NONE = 2'b00,
    RSB_OP_CMD = 2'b01,
    RSB_OP_DATA = 2'b10,
    RSB_OP_TSW = 2'b11
  } rsb_oper_t;

  // Access state machine, one-hot
  typedef enum logic [2:0] {
    RSB_IDLE = 3'b001,
    RSB_REQ = 3'b010,
    RSB_REL = 3'b100
  } rsb_fsm_t;

  // Asynchronous pins, synchronised together
  typedef struct packed {
    logic [4:0] terminal_address_input;
    logic subsystem_flag_input;
    logic terminal_busy_input;
    logic terminal_flag_input;
    logic command_write_enable;
    logic status_record_write_enable;
    logic mem_gnt_n;
  } rsb_pins_t;

  // Error flags reported at end of transfer
  typedef struct packed {
    logic loopback_fail_b;
    logic loopback_fail_a;
    logic illegal_cmd;
    logic biphase_code_error;
    logic odd_check_error;
    logic word_count_error;
  } rsb_xfer_err_t;

  // Data access request from the protocol logic
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rsb_data_req_t;

  // Backend memory port outputs
  typedef struct packed {
    logic req_n;
    logic write;
    rsb_oper_t oper;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rsb_mem_out_t;

  // Whole state of the main module
  typedef struct packed {
    rsb_pins_t s1;
    rsb_pins_t s2;
    rsb_pins_t s3;
    rsb_pins_t pf;
    rsb_fsm_t fsm;
    logic [DATA_W-1:0] cmd;
    logic msg_err;
    logic bcast_rx;
    logic inhibit;
    logic mem_fail;
    logic pend_cmd;
    logic pend_data;
    logic pend_tsw;
    rsb_data_req_t dreq;
    logic [DATA_W-1:0] tsw_word;
    rsb_mem_out_t mem;
    logic [DATA_W-1:0] rdata;
    logic data_done;
    logic data_fail;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] cval;
    logic addr_strobe;
    logic int_strobe;
    logic [6:0] int_vec;
  } rsb_state_t;

  // Timer state
  typedef struct packed {
    logic [TIMER_W-1:0] count;
  } rsb_timer_t;

endpackage : rsb_pkg

// >>> hdl/rsb_access_timer.sv
// Watchdog that bounds each backend memory access
`timescale 1ns/1ps
module rsb_access_timer (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic run,
  output logic timeout
);

  rsb_pkg::rsb_timer_t r_r;
  rsb_pkg::rsb_timer_t r_nxt;

  // Count while an access is open, restart when it closes
  always_comb begin
    r_nxt = r_r;
    if (!run) begin
      r_nxt.count = '0;
    end else if (!timeout) begin
      r_nxt.count = r_r.count + 7'h01;
    end
  end

  // Fires on the last allowed cycle of the access
  assign timeout = run && (r_r.count == 7'(rsb_pkg::TIMEOUT_CYC - 1));

  always_ff @(posedge clk) begin
    if (reset) begin
      r_r <= '0;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

endmodule : rsb_access_timer

// >>> tb/rsb_backend_asserts.sv
// Concurrent checks on the status word, transfer record and memory port
`timescale 1ns/1ps
module rsb_backend_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmd_start,
  input wire logic [15:0] cmd_word,
  input wire logic xfer_end,
  input wire logic bus_select_flag,
  input wire logic xfer_broadcast,
  input wire rsb_pkg::rsb_xfer_err_t xfer_err,
  input wire logic [4:0] terminal_address_input,
  input wire logic subsystem_flag_input,
  input wire logic terminal_busy_input,
  input wire logic [15:0] status_word,
  input wire logic [15:0] transfer_status_record,
  input wire logic [15:0] command_value_bus,
  input wire logic address_latch_strobe,
  input wire logic interrupt_latch_strobe,
  input wire logic [6:0] int_vector,
  input wire logic mem_req_n,
  input wire rsb_pkg::rsb_oper_t mem_oper,
  input wire logic [10:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic memory_timeout_flag
);
  logic [6:0] open_r;
  logic [6:0] open_nxt;
  logic [10:0] loc;
  default clocking @(posedge clk); endclocking
  default disable iff (reset || !ce);
  // Length of the open access; an access that ends returns it to zero
  always_comb open_nxt = (mem_oper == rsb_pkg::RSB_OP_NONE) ? 7'h00 : open_r + 7'h01;
  always_ff @(posedge clk) open_r <= reset ? 7'h00 : open_nxt;
  // Record slot of the current command
  assign loc = {command_value_bus[10] ? 6'h1F : 6'h00, command_value_bus[9:5]};
  a_sw_fixed_zero: assert property (!status_word[9] && status_word[7:5] == 3'h0
    && !status_word[1]) else $error("fixed status bits not zero");
  a_sw_pin_copy: assert property (
    $stable({terminal_address_input, subsystem_flag_input, terminal_busy_input}) [*8]
    |-> status_word[15:11] == terminal_address_input && status_word[3] == terminal_busy_input
    && status_word[8] == subsystem_flag_input && status_word[2] == subsystem_flag_input)
    else $error("status word does not follow pins");
  a_cmd_capture: assert property (address_latch_strobe == $past(cmd_start)
    && (!address_latch_strobe || command_value_bus == $past(cmd_word)))
    else $error("command value or latch strobe wrong");
  a_vec_latch: assert property (xfer_end |=> interrupt_latch_strobe
    && int_vector == {transfer_status_record[14], command_value_bus[10:5]})
    else $error("interrupt vector wrong");
  a_rec_flags: assert property (xfer_end |=> transfer_status_record[15]
    && transfer_status_record[14] == (transfer_status_record[11:5] == 7'h00))
    else $error("record used or ok bit wrong");
  a_rec_fields: assert property (xfer_end |=> transfer_status_record[13:9] ==
    $past({bus_select_flag, xfer_broadcast, xfer_err[5:3]})
    && transfer_status_record[7:5] == $past(xfer_err[2:0]))
    else $error("record error fields wrong");
  a_rec_location: assert property ($fell(mem_req_n)
    && mem_oper inside {rsb_pkg::RSB_OP_CMD, rsb_pkg::RSB_OP_TSW} |-> mem_addr == loc
    && mem_wdata == (mem_oper == rsb_pkg::RSB_OP_CMD ? command_value_bus
    : transfer_status_record)) else $error("command or record write misplaced");
  a_access_bound: assert property (open_r <= 7'h33)
    else $error("access open past the limit");
  a_abort_flag: assert property ($rose(memory_timeout_flag) |-> open_r >= 7'h30
    && mem_req_n && mem_oper == rsb_pkg::RSB_OP_NONE) else $error("timeout flag without abort");
endmodule : rsb_backend_asserts

bind rsb_backend rsb_backend_asserts chk_u (.*);

// >>> tb/rsb_mem_model.sv
// Behavioural backend memory on the request and grant handshake
`timescale 1ns/1ps
module rsb_mem_model (
  input wire logic clk,
  input wire logic mem_req_n,
  input wire logic mem_write,
  input wire logic [10:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic stall,
  input wire logic [3:0] lat,
  output logic mem_gnt_n,
  output logic [15:0] mem_rdata
);
  logic [15:0] ram [2048];
  logic [3:0] wait_r = 4'h0;
  initial mem_gnt_n = 1'b1;
  initial mem_rdata = 16'h0000;
  // Grant after lat cycles; stall withholds it so the device must abort
  // grant well inside the access limit
  always @(posedge clk) begin
    if (mem_req_n) begin
      mem_gnt_n <= 1'b1;
      wait_r <= 4'h0;
      mem_rdata <= ~mem_rdata; // Released bus does not keep old data
    end else if (mem_gnt_n && !stall) begin
      wait_r <= wait_r + 4'h1;
      if (wait_r == lat) begin
        mem_gnt_n <= 1'b0;
        mem_rdata <= ram[mem_addr];
        if (mem_write) ram[mem_addr] <= mem_wdata;
      end
    end
  end
endmodule : rsb_mem_model

// >>> tb/rsb_backend_tb_top.sv
// Self-checking bench for the status word and transfer record backend
`timescale 1ns/1ps
module rsb_backend_tb_top;
  logic clk = 1'b0, reset = 1'b1, ss = 1'b0, busy = 1'b0, tf = 1'b0, cwe = 1'b0, twe = 1'b0;
  logic cs = 1'b0, me = 1'b0, br = 1'b0, ih = 1'b0, ic = 1'b0, xe = 1'b0, bsel = 1'b0;
  logic xb = 1'b0, dreq = 1'b0, stall = 1'b0, last_n = 1'b1;
  logic gnt_n, rdy, done, fail, req_n, wr, tmo;
  logic [3:0] lat = 4'h0;
  logic [4:0] ta = 5'h00, wc = 5'h00;
  logic [15:0] cw = 16'h0000, rd, mrd, wd, sw, rec;
  logic [10:0] ad;
  logic [6:0] vec;
  logic ce = 1'b1, als, ils;
  logic [15:0] cval, map_cmd = 16'h0000;
  logic [6:0] map_vec = 7'h00;
  logic [5:0] oplog = 6'h00;
  int miscompares = 0, n_tests = 0, nops = 0;
  rsb_pkg::rsb_xfer_err_t err = 6'h00;
  rsb_pkg::rsb_data_req_t dinfo = 28'h000_0000;
  rsb_pkg::rsb_oper_t op;
  always #10 clk = ~clk;
  rsb_backend dut_u (.clk(clk), .reset(reset), .ce(ce), .terminal_address_input(ta),
    .subsystem_flag_input(ss), .terminal_busy_input(busy), .terminal_flag_input(tf),
    .command_write_enable(cwe), .status_record_write_enable(twe), .cmd_start(cs),
    .cmd_word(cw), .msg_error_set(me), .bcast_rx_set(br), .inhibit_terminal_flag_input_set(ih),
    .inhibit_terminal_flag_input_clr(ic), .xfer_end(xe), .bus_select_flag(bsel), .xfer_broadcast(xb),
    .xfer_err(err), .word_count(wc), .data_req(dreq), .data_req_info(dinfo),
    .data_ready(rdy), .data_done(done), .data_fail(fail), .data_rdata(rd),
    .mem_req_n(req_n), .mem_gnt_n(gnt_n), .mem_write(wr), .mem_oper(op), .mem_addr(ad),
    .mem_wdata(wd), .mem_rdata(mrd), .status_word(sw), .transfer_status_record(rec),
    .command_value_bus(cval), .address_latch_strobe(als), .interrupt_latch_strobe(ils),
    .int_vector(vec), .memory_timeout_flag(tmo));
  rsb_mem_model mem_u (.clk(clk), .mem_req_n(req_n), .mem_write(wr), .mem_addr(ad),
    .mem_wdata(wd), .stall(stall), .lat(lat), .mem_gnt_n(gnt_n), .mem_rdata(mrd));
  always @(posedge clk) begin
    if (als) map_cmd <= cval;
    if (ils) map_vec <= vec;
  end
  // Log the kind of each new access to see the service order
  always @(negedge clk) begin
    if (!req_n && last_n) begin
      oplog <= {oplog[3:0], op};
      nops <= nops + 1;
    end
    last_n <= req_n;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // Pin copies, fixed zeros, event bits and the flag inhibit
  task automatic t_status;
    @(posedge clk);
    {ta, ss, busy, tf} <= {5'h15, 3'b101};
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("status", sw, 16'hA905);
    @(posedge clk);
    {ta, ss, busy, ih, me, br} <= {5'h0A, 5'b01111};
    @(posedge clk);
    {ih, me, br} <= 3'b000;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("status inhibited", sw, 16'h5418);
    @(posedge clk);
    ic <= 1'b1;
    @(posedge clk);
    ic <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("flag restored", sw[0], 1'b1);
    // Clock enable low freezes the filter and the status word
    @(posedge clk);
    {ce, ta} <= {1'b0, 5'h1F};
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("frozen status", sw, 16'h5419);
    @(posedge clk);
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("thawed status", sw, 16'hFC19);
  endtask : t_status
  // One whole transfer: command, one data access, end with its record
  task automatic t_xfer(input logic tx, input logic [4:0] sa, input logic c_en, t_en, stl,
      input logic [5:0] e, input logic [1:0] bb, input logic [4:0] n);
    logic [15:0] cmd, exp;
    logic [10:0] loc, da;
    logic [5:0] ops;
    int k, nexp;
    cmd = {5'h15, tx, sa, 5'h11};
    loc = {tx ? 6'h1F : 6'h00, sa};
    da = {tx ? 6'h21 : 6'h01, sa};
    exp = {1'b1, ~(|e) & ~stl, bb, e[5:3], stl, e[2:0], (sa == 5'h00 || sa == 5'h1F) ? 5'h11 : n};
    ops = c_en ? 6'h06 : 6'h02;
    ops = t_en ? {ops[3:0], 2'h3} : ops;
    nexp = 1 + c_en + t_en;
    mem_u.ram[loc] = 16'h0000;
    mem_u.ram[da] = 16'hC3A5;
    @(posedge clk);
    {cwe, twe, stall, lat} <= {c_en, t_en, stl, 1'b0, sa[2:0]};
    repeat (8) @(posedge clk);
    nops = 0;
    oplog = 6'h00;
    {cs, cw} <= {1'b1, cmd};
    @(posedge clk);
    {cs, dreq, dinfo} <= {1'b0, 1'b1, ~tx, da, 16'h5A3C};
    k = 0;
    do @(negedge clk); while (!rdy && ++k < 50);
    chk("ready wait", k == 50, 1'b0);
    @(posedge clk);
    dreq <= 1'b0;
    k = 0;
    do @(negedge clk); while (!done && ++k < 200);
    chk("done wait", k == 200, 1'b0);
    chk("data fail", fail, stl);
    if (tx) chk("read data", rd, 16'hC3A5);
    @(posedge clk);
    {stall, xe, bsel, xb, err, wc} <= {1'b0, 1'b1, bb, e, n};
    @(posedge clk);
    xe <= 1'b0;
    @(negedge clk);
    chk("record", rec, exp);
    chk("vector", vec, {exp[14], tx, sa});
    chk("timeout flag", tmo, stl);
    k = 0;
    do @(negedge clk); while ((nops < nexp || op != rsb_pkg::RSB_OP_NONE) && ++k < 300);
    chk("access wait", k == 300, 1'b0);
    chk("mapped command", map_cmd, cmd);
    chk("mapped vector", map_vec, {exp[14], tx, sa});
    chk("access order", oplog, ops);
    chk("slot", mem_u.ram[loc], t_en ? exp : c_en ? cmd : 16'h0000);
    if (!tx && !stl) chk("rx data", mem_u.ram[da], 16'h5A3C);
  endtask : t_xfer
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200_000;
    miscompares++;
    conclude();
  end
  // Reset, then status checks and a table of transfers
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_status();
    t_xfer(1'b0, 5'h03, 1'b1, 1'b1, 1'b0, 6'h00, 2'b00, 5'h04);
    t_xfer(1'b1, 5'h18, 1'b1, 1'b1, 1'b0, 6'h20, 2'b10, 5'h00);
    t_xfer(1'b0, 5'h00, 1'b0, 1'b1, 1'b0, 6'h07, 2'b01, 5'h07);
    t_xfer(1'b1, 5'h1F, 1'b1, 1'b0, 1'b0, 6'h18, 2'b00, 5'h01);
    t_xfer(1'b0, 5'h02, 1'b0, 1'b0, 1'b1, 6'h00, 2'b10, 5'h02);
    conclude();
  end
endmodule : rsb_backend_tb_top
